// ==== fkm_pkg.sv ====
// Purpose: constants and carrier types for the key and margin command sequencer
// Assumes: apb slave, 32-bit data, byte addresses, one word per register
// Notes:   offsets, bit positions and command codes are defined here; the read mux and the bench also use literal positions and codes
package fkm_pkg;
  // register byte offsets
  localparam logic [7:0]  FKM_STAT_OFS   = 8'h00;
  localparam logic [7:0]  FKM_IDX_OFS    = 8'h04;
  localparam logic [7:0]  FKM_CCOB_OFS   = 8'h08;
  localparam logic [7:0]  FKM_SEC_OFS    = 8'h0C;
  localparam logic [7:0]  FKM_STATE_OFS  = 8'h10;
  localparam logic [7:0]  FKM_MARGIN_OFS = 8'h14;
  // status and security field positions
  localparam int          FKM_COMMAND_COMPLETE_FLAG_BIT   = 7;
  localparam int          FKM_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int          FKM_KEY_ENABLE_FIELD_MSB  = 7;
  localparam int          FKM_KEY_ENABLE_FIELD_LSB  = 6;
  localparam int          FKM_DF_LSB     = 4;
  // reset values
  localparam logic [7:0]  FKM_SEC_RST    = 8'h00;
  localparam logic [2:0]  FKM_MG_NORMAL  = 3'h0;
  // command codes and launch indices
  localparam logic [7:0]  FKM_CMD_KEY    = 8'h0C;
  localparam logic [7:0]  FKM_CMD_UMARG  = 8'h0D;
  localparam logic [7:0]  FKM_CMD_FMARG  = 8'h0E;
  localparam logic [2:0]  FKM_IX_KEY     = 3'h4;
  localparam logic [2:0]  FKM_IX_MARGIN  = 3'h1;
  localparam logic [1:0]  FKM_KEY_ENABLE_FIELD_ON   = 2'h2;
  // comparison key location and margin settings
  localparam logic [22:0] FKM_KEY_BASE   = 23'h7FFF00;
  localparam logic [22:0] FKM_KEY_STEP   = 23'h000002;
  localparam logic [1:0]  FKM_KEY_LAST   = 2'h3;
  localparam logic [15:0] FKM_UMARG_MAX  = 16'h0002;
  localparam logic [15:0] FKM_FMARG_MAX  = 16'h0004;

  typedef enum logic [2:0] {FKM_IDLE, FKM_CHECK, FKM_KEY_REQ, FKM_KEY_CMP, FKM_DONE} fkm_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fkm_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fkm_apb_rsp_t;

  typedef struct packed {
    logic        en;
    logic [22:0] addr;
  } fkm_key_rd_t;
endpackage : fkm_pkg

// ==== fkm_seq.sv ====
// Purpose: backdoor key verify and margin level commands of a flash sequencer
// Assumes: apb register access, flash word read port with one cycle latency
// Notes:   commands launch by writing one to the complete flag while it is set
//
// Overview of operation
// - key command 0x0C, keys at indices 1-4
// - key launch index not 4 sets error
// - key enable field not 10 aborts with error
// - compare keys in order from 0x7F_FF00
// - all keys match releases security
// - wrong key sets error, security kept
// - mismatch locks out key command until reset
// - complete flag sets after key command ends
// - user margin 0x0D, block, setting index 1
// - user margin stored, applied, then complete
// - user margin accepts settings 0 to 2
// - margin launch index not 1 sets error
// - unknown block address sets error
// - unaccepted margin setting sets error
// - command unavailable in mode sets error
// - field margin 0x0E runs in special mode
// - field margin also accepts 3 and 4
// - field margin applied, then complete
//
// Added by the designer: the APB register port and the placing of the registers.
module fkm_seq
  import fkm_pkg::*;
#(
  parameter logic [6:0] PF_BLOCK_ID = 7'h7F,
  parameter logic [6:0] DF_BLOCK_ID = 7'h10
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // register bus
  input  wire fkm_pkg::fkm_apb_req_t apb_req,
  output fkm_pkg::fkm_apb_rsp_t  apb_rsp,
  // comparison key read port
  output fkm_pkg::fkm_key_rd_t   key_rd,
  input  wire logic [15:0]       key_rd_data,
  // operating mode
  input  wire logic              special_mode,
  // margin levels and security state
  output logic [2:0]             margin_pf,
  output logic [2:0]             margin_df,
  output logic                   secured
);
  import fkm_pkg::*;

  typedef struct packed {
    fkm_state_t        state;
    logic              command_complete_flag;
    logic              access_error_flag;
    logic [2:0]        ix;
    logic [7:0][15:0]  ccob;
    logic [7:0]        sec_cfg;
    logic              secured;
    logic              lockout;
    logic [1:0]        key_i;
    logic [1:0][2:0]   margin;
    fkm_key_rd_t       key_rd;
    fkm_apb_rsp_t      rsp;
  } fkm_regs_t;

  fkm_regs_t s_r;
  fkm_regs_t s_nxt;

  // byte address of the comparison key word for a key number
  function automatic logic [22:0] fkm_key_addr(input logic [1:0] i);
    fkm_key_addr = FKM_KEY_BASE + FKM_KEY_STEP * {21'h0, i};
  endfunction

  // setting accepted by the given margin command
  function automatic logic fkm_margin_ok(input logic [7:0] code, input logic [15:0] val);
    fkm_margin_ok = (code == FKM_CMD_FMARG) ? (val <= FKM_FMARG_MAX)
                                            : (val <= FKM_UMARG_MAX);
  endfunction

  // decoded launch parameters
  logic [7:0]  cmd_code;
  logic [6:0]  blk_gaddr;
  logic        blk_valid;
  logic        blk_is_df;
  logic        key_ready;
  logic        margin_bad;
  logic        key_match;
  logic        access;
  logic        commit;
  logic        launch;
  logic        margin_cmd;

  assign cmd_code   = s_r.ccob[0][15:8];
  assign blk_gaddr  = s_r.ccob[0][6:0];
  assign blk_is_df  = (blk_gaddr == DF_BLOCK_ID);
  assign blk_valid  = blk_is_df || (blk_gaddr == PF_BLOCK_ID);
  assign key_ready  = (s_r.ix == FKM_IX_KEY) && !s_r.lockout &&
                      (s_r.sec_cfg[FKM_KEY_ENABLE_FIELD_MSB:FKM_KEY_ENABLE_FIELD_LSB] == FKM_KEY_ENABLE_FIELD_ON);
  assign margin_bad = (s_r.ix != FKM_IX_MARGIN) || !blk_valid ||
                      !fkm_margin_ok(cmd_code, s_r.ccob[1]) ||
                      (cmd_code == FKM_CMD_FMARG && !special_mode);
  assign key_match  = (key_rd_data == s_r.ccob[3'(s_r.key_i) + 3'h1]);
  assign access     = apb_req.psel && apb_req.penable;
  assign commit     = access && s_r.rsp.pready && apb_req.pwrite && !s_r.rsp.pslverr;
  assign launch     = commit && apb_req.paddr == FKM_STAT_OFS &&
                      apb_req.pwdata[FKM_COMMAND_COMPLETE_FLAG_BIT] && s_r.command_complete_flag;
  assign margin_cmd = (cmd_code == FKM_CMD_UMARG) || (cmd_code == FKM_CMD_FMARG);

  // next state: bus first, sequencer after so that hardware sets win
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.pready = 1'b0;
    s_nxt.rsp.pslverr = 1'b0;
    // apb: one wait state, read data registered
    if (access && !s_r.rsp.pready)
    begin
      s_nxt.rsp.pready  = 1'b1;
      s_nxt.rsp.pslverr = 1'b0;
      s_nxt.rsp.prdata  = 32'h0;
      case (apb_req.paddr)
        FKM_STAT_OFS:   s_nxt.rsp.prdata = {24'h0, s_r.command_complete_flag, 1'b0, s_r.access_error_flag, 5'h0};
        FKM_IDX_OFS:    s_nxt.rsp.prdata = {29'h0, s_r.ix};
        FKM_CCOB_OFS:   s_nxt.rsp.prdata = {16'h0, s_r.ccob[s_r.ix]};
        FKM_SEC_OFS:    s_nxt.rsp.prdata = {24'h0, s_r.sec_cfg};
        FKM_STATE_OFS:  s_nxt.rsp.prdata = {29'h0, special_mode, s_r.lockout, s_r.secured};
        FKM_MARGIN_OFS: s_nxt.rsp.prdata = {25'h0, s_r.margin[1], 1'b0, s_r.margin[0]};
        default:        s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
    // register writes, ignored while a command runs
    if (commit && s_r.command_complete_flag)
    begin
      case (apb_req.paddr)
        FKM_STAT_OFS:
        begin
          if (apb_req.pwdata[FKM_ACCESS_ERROR_FLAG_BIT])
            s_nxt.access_error_flag = 1'b0;
          if (launch && !s_r.access_error_flag)
          begin
            s_nxt.command_complete_flag  = 1'b0;
            s_nxt.state = FKM_CHECK;
          end
        end
        FKM_IDX_OFS:  s_nxt.ix = apb_req.pwdata[2:0];
        FKM_CCOB_OFS: s_nxt.ccob[s_r.ix] = apb_req.pwdata[15:0];
        FKM_SEC_OFS:  s_nxt.sec_cfg = apb_req.pwdata[7:0];
        default:      s_nxt.ix = s_r.ix;
      endcase
    end
    // command sequencer
    case (s_r.state)
      FKM_IDLE: s_nxt.key_rd.en = 1'b0;
      FKM_CHECK:
      begin
        s_nxt.state = FKM_DONE;
        case (cmd_code)
          FKM_CMD_KEY:
          begin
            if (key_ready)
            begin
              s_nxt.key_i  = 2'h0;
              s_nxt.key_rd = '{en: 1'b1, addr: fkm_key_addr(2'h0)};
              s_nxt.state  = FKM_KEY_REQ;
            end
            else
              s_nxt.access_error_flag = 1'b1;
          end
          FKM_CMD_UMARG, FKM_CMD_FMARG:
          begin
            if (margin_bad)
              s_nxt.access_error_flag = 1'b1;
            else
              s_nxt.margin[blk_is_df] = s_r.ccob[1][2:0];
          end
          default: s_nxt.access_error_flag = 1'b1;
        endcase
      end
      FKM_KEY_REQ:
      begin
        s_nxt.key_rd.en = 1'b0;
        s_nxt.state     = FKM_KEY_CMP;
      end
      FKM_KEY_CMP:
      begin
        if (!key_match)
        begin
          s_nxt.access_error_flag  = 1'b1;
          s_nxt.lockout = 1'b1;
          s_nxt.state   = FKM_DONE;
        end
        else if (s_r.key_i == FKM_KEY_LAST)
        begin
          s_nxt.secured = 1'b0;
          s_nxt.state   = FKM_DONE;
        end
        else
        begin
          s_nxt.key_i  = s_r.key_i + 2'h1;
          s_nxt.key_rd = '{en: 1'b1, addr: fkm_key_addr(s_r.key_i + 2'h1)};
          s_nxt.state  = FKM_KEY_REQ;
        end
      end
      FKM_DONE:
      begin
        s_nxt.command_complete_flag  = 1'b1;
        s_nxt.state = FKM_IDLE;
      end
      default: s_nxt.state = FKM_IDLE;
    endcase
  end

  // state register, margins normal and security set at reset
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_r         <= '0;
      s_r.state   <= FKM_IDLE;
      s_r.command_complete_flag    <= 1'b1;
      s_r.sec_cfg <= FKM_SEC_RST;
      s_r.secured <= 1'b1;
      s_r.margin  <= {FKM_MG_NORMAL, FKM_MG_NORMAL};
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign apb_rsp   = s_r.rsp;
  assign key_rd    = s_r.key_rd;
  assign margin_pf = s_r.margin[0];
  assign margin_df = s_r.margin[1];
  assign secured   = s_r.secured;

  // checks
  key_index_err_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_KEY && s_r.ix != FKM_IX_KEY
    |=> s_r.access_error_flag && s_r.state == FKM_DONE)
    else $error("key launch at wrong index gave no error");

  key_enable_chk_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_KEY &&
    s_r.sec_cfg[FKM_KEY_ENABLE_FIELD_MSB:FKM_KEY_ENABLE_FIELD_LSB] != FKM_KEY_ENABLE_FIELD_ON
    |=> s_r.access_error_flag && !s_r.key_rd.en)
    else $error("disabled key command was not aborted");

  key_first_addr_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_KEY && key_ready
    |=> s_r.key_rd.en && s_r.key_rd.addr == FKM_KEY_BASE ##1 s_r.state == FKM_KEY_CMP)
    else $error("first key word not read from base");

  key_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_KEY_CMP && key_match && s_r.key_i == FKM_KEY_LAST
    |=> !s_r.secured ##1 s_r.command_complete_flag)
    else $error("matching keys did not release security");

  key_mismatch_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_KEY_CMP && !key_match
    |=> s_r.access_error_flag && s_r.lockout && s_r.secured == $past(s_r.secured))
    else $error("key mismatch handled wrongly");

  lockout_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.lockout |=> s_r.lockout)
    else $error("key lockout cleared before reset");

  cmd_finish_a: assert property (@(posedge sys_clk) disable iff (reset)
    launch && !s_r.access_error_flag |=> !s_r.command_complete_flag ##[1:12] s_r.command_complete_flag)
    else $error("command did not complete in time");

  margin_apply_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && (cmd_code == FKM_CMD_UMARG || cmd_code == FKM_CMD_FMARG)
    && !margin_bad |=> s_r.margin[$past(blk_is_df)] == $past(s_r.ccob[1][2:0])
    && !s_r.access_error_flag ##1 s_r.command_complete_flag)
    else $error("margin level not applied");

  margin_reject_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && (cmd_code == FKM_CMD_UMARG || cmd_code == FKM_CMD_FMARG)
    && margin_bad |=> s_r.access_error_flag && $stable(s_r.margin))
    else $error("bad margin command not rejected");

  field_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_FMARG && !special_mode
    |=> s_r.access_error_flag)
    else $error("field margin ran outside special mode");

  // key port sequencing and margin parameter checks
  key_step_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.key_rd.en && s_r.key_i != 2'h0
    |-> s_r.key_rd.addr == $past(s_r.key_rd.addr, 2) + FKM_KEY_STEP)
    else $error("key words not read in order");

  key_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.key_rd.en
    |=> !s_r.key_rd.en)
    else $error("key read request longer than one cycle");

  lock_abort_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_KEY && s_r.lockout
    |=> s_r.access_error_flag && !s_r.key_rd.en && s_r.secured == $past(s_r.secured))
    else $error("locked out key command not aborted");

  key_done_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_DONE
    |=> s_r.command_complete_flag && s_r.state == FKM_IDLE)
    else $error("complete flag not set at end of command");

  margin_index_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && margin_cmd && s_r.ix != FKM_IX_MARGIN
    |=> s_r.access_error_flag && $stable(s_r.margin))
    else $error("margin launch at wrong index accepted");

  block_addr_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && margin_cmd && blk_gaddr != PF_BLOCK_ID && blk_gaddr != DF_BLOCK_ID
    |=> s_r.access_error_flag && $stable(s_r.margin))
    else $error("unknown block address accepted");

  user_setting_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_UMARG && s_r.ccob[1] > FKM_UMARG_MAX
    |=> s_r.access_error_flag && $stable(s_r.margin))
    else $error("user margin accepted a bad setting");

  field_setting_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_FMARG && s_r.ccob[1] > FKM_FMARG_MAX
    |=> s_r.access_error_flag && $stable(s_r.margin))
    else $error("field margin accepted a bad setting");

  margin_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.state != FKM_CHECK
    |=> $stable(s_r.margin))
    else $error("margin level changed outside a command");

  cov_key_ok_c: cover property (@(posedge sys_clk) disable iff (reset)
    s_r.secured ##1 !s_r.secured);
  cov_lockout_c: cover property (@(posedge sys_clk) disable iff (reset)
    !s_r.lockout ##1 s_r.lockout);
  cov_field_c: cover property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_FMARG && !margin_bad);
  cov_margin_err_c: cover property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && margin_cmd && margin_bad);
  cov_key_abort_c: cover property (@(posedge sys_clk) disable iff (reset)
    s_r.state == FKM_CHECK && cmd_code == FKM_CMD_KEY && !key_ready);
endmodule // fkm_seq

// ==== fkm_tb.sv ====
// Purpose: self-checking bench for the key and margin command sequencer
// Assumes: apb slave with one wait state, key words answered the cycle after a request
// Notes:   the bench answers the key read port itself, no separate partner
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fkm_pkg::*;

  typedef struct packed {
    logic        sm;
    logic [7:0]  code;
    logic [6:0]  blk;
    logic [2:0]  ix;
    logic [15:0] set;
    logic        err;
  } fkm_tc_t;

  logic          sys_clk;
  logic          reset;
  logic          special_mode;
  logic          rd_v = 1'b0;
  logic [15:0]   pat = 16'h1234;
  fkm_apb_req_t  req;
  fkm_apb_rsp_t  rsp;
  fkm_key_rd_t   key_rd;
  logic [15:0]   key_rd_data;
  logic [2:0]    margin_pf;
  logic [2:0]    margin_df;
  logic          secured;
  logic [15:0]   keys [4];
  logic [15:0]   sup [5];
  logic [22:0]   rd_addr [$];
  int            failures;
  int            n_checks;

  fkm_seq DUT (.sys_clk(sys_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .key_rd(key_rd), .key_rd_data(key_rd_data), .special_mode(special_mode),
    .margin_pf(margin_pf), .margin_df(margin_df), .secured(secured));

  // 250 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // key word is valid only the cycle after a request, noise otherwise
  always @(posedge sys_clk)
  begin
    rd_v <= key_rd.en;
    pat  <= pat + 16'h3C5B;
    if (key_rd.en === 1'b1) rd_addr.push_back(key_rd.addr);
  end
  assign key_rd_data = rd_v ? keys[key_rd.addr[2:1]] : pat;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    req.psel <= 1'b1; req.penable <= 1'b0; req.pwrite <= w; req.paddr <= a; req.pwdata <= d;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) failures++;
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0; req.penable <= 1'b0;
  endtask

  task automatic do_reset;
    reset <= 1'b1;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
  endtask

  // load words 0..ix, launch, wait for completion and return the error flag
  task automatic cmd(input logic [2:0] ix, output logic err);
    logic [31:0] r;
    logic        e;
    int          n;
    for (int i = 0; i <= int'(ix); i++)
    begin
      apb(1'b1, FKM_IDX_OFS, 32'(i), r, e);
      apb(1'b1, FKM_CCOB_OFS, {16'h0000, sup[i]}, r, e);
    end
    apb(1'b1, FKM_STAT_OFS, 32'h0000_0020, r, e);
    apb(1'b1, FKM_STAT_OFS, 32'h0000_0080, r, e);
    n = 0;
    r = '0;
    while (r[7] !== 1'b1 && n < 20)
    begin
      apb(1'b0, FKM_STAT_OFS, 32'h0, r, e); // only reads while busy
      n++;
    end
    check({31'h0, r[7]}, 32'h1);
    err = r[5];
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    apb(1'b0, FKM_STAT_OFS, 32'h0, r, e);
    check(r, 32'h0000_0080);
    apb(1'b0, FKM_SEC_OFS, 32'h0, r, e);
    check(r, 32'h0);
    apb(1'b0, FKM_STATE_OFS, 32'h0, r, e);
    check(r, {29'h0, special_mode, 2'b01});
    apb(1'b0, FKM_MARGIN_OFS, 32'h0, r, e);
    check(r, 32'h0);
    apb(1'b0, 8'h18, 32'h0, r, e);
    check({e, r[30:0]}, 32'h8000_0000);
  endtask

  task automatic t_margin;
    fkm_tc_t     tc [12];
    logic [2:0]  exp_pf;
    logic [2:0]  exp_df;
    logic [31:0] r;
    logic        e;
    tc = '{'{1'b0, FKM_CMD_UMARG, 7'h7F, 3'h1, 16'h0001, 1'b0},
           '{1'b0, FKM_CMD_UMARG, 7'h10, 3'h1, 16'h0002, 1'b0},
           '{1'b0, FKM_CMD_UMARG, 7'h7F, 3'h1, 16'h0000, 1'b0},
           '{1'b0, FKM_CMD_UMARG, 7'h7F, 3'h1, 16'h0003, 1'b1},
           '{1'b0, FKM_CMD_UMARG, 7'h10, 3'h0, 16'h0001, 1'b1},
           '{1'b0, FKM_CMD_UMARG, 7'h05, 3'h1, 16'h0001, 1'b1},
           '{1'b0, FKM_CMD_FMARG, 7'h7F, 3'h1, 16'h0001, 1'b1},
           '{1'b1, FKM_CMD_UMARG, 7'h10, 3'h1, 16'h0000, 1'b0},
           '{1'b1, FKM_CMD_FMARG, 7'h7F, 3'h1, 16'h0003, 1'b0}, // factory verify only
           '{1'b1, FKM_CMD_FMARG, 7'h10, 3'h1, 16'h0004, 1'b0}, // factory verify only
           '{1'b1, FKM_CMD_FMARG, 7'h7F, 3'h1, 16'h0005, 1'b1},
           '{1'b0, 8'h0F, 7'h7F, 3'h1, 16'h0000, 1'b1}};
    exp_pf = 3'h0;
    exp_df = 3'h0;
    foreach (tc[i])
    begin
      special_mode <= tc[i].sm;
      sup[0] = {tc[i].code, 1'b0, tc[i].blk};
      sup[1] = tc[i].set;
      cmd(tc[i].ix, e);
      check({31'h0, e}, {31'h0, tc[i].err});
      if (!tc[i].err && tc[i].blk == 7'h7F) exp_pf = tc[i].set[2:0];
      if (!tc[i].err && tc[i].blk == 7'h10) exp_df = tc[i].set[2:0];
      apb(1'b0, FKM_MARGIN_OFS, 32'h0, r, e);
      check(r, {25'h0, exp_df, 1'b0, exp_pf});
      check({26'h0, margin_df, margin_pf}, {26'h0, exp_df, exp_pf});
    end
    special_mode <= 1'b0;
  endtask

  task automatic t_key_ok;
    logic [31:0] r;
    logic        e;
    sup[0] = {FKM_CMD_KEY, 8'h00};
    for (int i = 0; i < 4; i++) sup[i + 1] = keys[i];
    cmd(3'h4, e); // keys supplied by bench, no flash code
    check({31'h0, e}, 32'h1);
    apb(1'b1, FKM_SEC_OFS, 32'h0000_0080, r, e);
    cmd(3'h3, e);
    check({31'h0, e}, 32'h1);
    rd_addr.delete();
    cmd(3'h4, e);
    check({30'h0, e, secured}, 32'h0);
    check(32'(rd_addr.size()), 32'h4);
    foreach (rd_addr[i]) check({9'h0, rd_addr[i]}, {9'h0, 23'h7FFF00 + 23'(2 * i)});
  endtask

  task automatic t_key_bad;
    logic [31:0] r;
    logic        e;
    apb(1'b1, FKM_SEC_OFS, 32'h0000_0080, r, e);
    sup[3] = keys[2] ^ 16'h0100;
    cmd(3'h4, e);
    check({31'h0, e}, 32'h1);
    check({31'h0, secured}, 32'h1);
    apb(1'b0, FKM_STATE_OFS, 32'h0, r, e);
    check(r, 32'h0000_0003);
    sup[3] = keys[2];
    cmd(3'h4, e);
    check({30'h0, e, secured}, 32'h3);
  endtask

  // watchdog
  initial
  begin
    #100000;
    failures++;
    results;
  end

  initial
  begin
    req = '0;
    reset = 1'b1;
    special_mode = 1'b0;
    failures = 0;
    n_checks = 0;
    keys = '{16'hA1B2, 16'h3C4D, 16'h5E6F, 16'h7081};
    do_reset;
    t_reset;
    t_margin;
    t_key_ok;
    do_reset;
    t_reset;
    t_key_bad;
    results;
  end
endmodule // testbench
